//--- hw/dac_datapath_cfg.sv
`timescale 1ns/100ps
// Behaviour
// [R1] pattern words three to five stored, reset 0x45, 0x1A, 0x16
// [R2] pattern words six and seven stored, reset 0xAA, 0xC6
// [R3] clock alarm mask keeps clock alarm off pin, status still set
// [R4] transmit-off mask keeps that alarm off pin, status still set
// [R5] clock monitor alarm only active while its enable bit is set
// [R6] auto-off enable forces both outputs to midscale on clock alarm
// [R7] channel A complement inverts channel A data
// [R8] channel B complement inverts channel B data
// [R9] divider sync enable aligns divider from the selected sync source
// [R10] sync select: 0 external strobe, 1 frame marker
// [R11] copy A to B drives channel A data onto channel B
// [R12] copy B to A drives channel B data onto channel A
// [R13] reversal bit reverses input word bit order
// [R14] pattern mismatch sets pattern-check alarm status bit
// [R15] eight-bit result field flags failing input lanes
// [R16] source sends words zero to seven in order; each byte compared
module dac_datapath_cfg #(
	parameter int div_width = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire dac_cfg_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic check_enable,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	input wire dac_cfg_pkg::sample_pair_t sample_in,
	input wire logic clk_monitor_fault,
	input wire logic tx_enable_fault,
	input wire logic external_sync_strobe,
	input wire logic frame_marker,
	output dac_cfg_pkg::sample_pair_t sample_out,
	output logic alarm_output_pin,
	output logic clk_alarm_status,
	output logic tx_off_status,
	output logic multi_sync_pulse,
	output logic [div_width-1:0] divider_phase
);
	logic [7:0] expected_word_zero, next_expected_word_zero;
	logic [7:0] expected_word_one, next_expected_word_one;
	logic [7:0] expected_word_two, next_expected_word_two;
	logic [7:0] expected_word_three, next_expected_word_three;
	logic [7:0] expected_word_four, next_expected_word_four;
	logic [7:0] expected_word_five, next_expected_word_five;
	logic [7:0] expected_word_six, next_expected_word_six;
	logic [7:0] expected_word_seven, next_expected_word_seven;
	logic [7:0] alarm_mask_enable_ctrl, next_alarm_mask_enable_ctrl;
	logic [7:0] polarity_sync_ctrl, next_polarity_sync_ctrl;
	logic [7:0] channel_route_sync_source, next_channel_route_sync_source;
	logic [7:0] next_reg_rdata;
	logic [7:0] check_results;
	logic check_alarm;
	logic clear_results;
	logic clear_alarm;
	logic [8*dac_cfg_pkg::word_count-1:0] expected_all;

	// ****************************************
	// register writes
	// ****************************************
	always_comb begin
		next_expected_word_zero = expected_word_zero;
		next_expected_word_one = expected_word_one;
		next_expected_word_two = expected_word_two;
		next_expected_word_three = expected_word_three;
		next_expected_word_four = expected_word_four;
		next_expected_word_five = expected_word_five;
		next_expected_word_six = expected_word_six;
		next_expected_word_seven = expected_word_seven;
		next_alarm_mask_enable_ctrl = alarm_mask_enable_ctrl;
		next_polarity_sync_ctrl = polarity_sync_ctrl;
		next_channel_route_sync_source = channel_route_sync_source;
		clear_results = 1'b0;
		clear_alarm = 1'b0;
		if (reg_req.wr) begin
			case (reg_req.addr)
				dac_cfg_pkg::addr_word0: next_expected_word_zero = reg_req.wdata;
				dac_cfg_pkg::addr_word1: next_expected_word_one = reg_req.wdata;
				dac_cfg_pkg::addr_word2: next_expected_word_two = reg_req.wdata;
				dac_cfg_pkg::addr_word3: next_expected_word_three = reg_req.wdata; // [R1]
				dac_cfg_pkg::addr_word4: next_expected_word_four = reg_req.wdata; // [R1]
				dac_cfg_pkg::addr_word5: next_expected_word_five = reg_req.wdata; // [R1]
				dac_cfg_pkg::addr_word6: next_expected_word_six = reg_req.wdata; // [R2]
				dac_cfg_pkg::addr_word7: next_expected_word_seven = reg_req.wdata; // [R2]
				dac_cfg_pkg::addr_alarm_ctrl: next_alarm_mask_enable_ctrl = reg_req.wdata;
				dac_cfg_pkg::addr_polarity_sync: next_polarity_sync_ctrl = reg_req.wdata;
				dac_cfg_pkg::addr_route_sync: next_channel_route_sync_source = reg_req.wdata;
				dac_cfg_pkg::addr_check_status: clear_alarm = 1'b1;
				dac_cfg_pkg::addr_check_results: clear_results = 1'b1;
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	always_comb begin
		next_reg_rdata = 8'h00;
		if (reg_req.rd) begin
			case (reg_req.addr)
				dac_cfg_pkg::addr_word0: next_reg_rdata = expected_word_zero;
				dac_cfg_pkg::addr_word1: next_reg_rdata = expected_word_one;
				dac_cfg_pkg::addr_word2: next_reg_rdata = expected_word_two;
				dac_cfg_pkg::addr_word3: next_reg_rdata = expected_word_three;
				dac_cfg_pkg::addr_word4: next_reg_rdata = expected_word_four;
				dac_cfg_pkg::addr_word5: next_reg_rdata = expected_word_five;
				dac_cfg_pkg::addr_word6: next_reg_rdata = expected_word_six;
				dac_cfg_pkg::addr_word7: next_reg_rdata = expected_word_seven;
				dac_cfg_pkg::addr_alarm_ctrl: next_reg_rdata = alarm_mask_enable_ctrl;
				dac_cfg_pkg::addr_polarity_sync: next_reg_rdata = polarity_sync_ctrl;
				dac_cfg_pkg::addr_route_sync: next_reg_rdata = channel_route_sync_source;
				dac_cfg_pkg::addr_check_status: begin
					next_reg_rdata[dac_cfg_pkg::bit_check_alarm] = check_alarm; // [R14]
				end
				dac_cfg_pkg::addr_check_results: next_reg_rdata = check_results; // [R15]
				default: next_reg_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// ****************************************
	// register storage
	// ****************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			expected_word_zero <= dac_cfg_pkg::rst_word0;
			expected_word_one <= dac_cfg_pkg::rst_word1;
			expected_word_two <= dac_cfg_pkg::rst_word2;
			expected_word_three <= dac_cfg_pkg::rst_word3; // [R1]
			expected_word_four <= dac_cfg_pkg::rst_word4; // [R1]
			expected_word_five <= dac_cfg_pkg::rst_word5; // [R1]
			expected_word_six <= dac_cfg_pkg::rst_word6; // [R2]
			expected_word_seven <= dac_cfg_pkg::rst_word7; // [R2]
			alarm_mask_enable_ctrl <= dac_cfg_pkg::rst_alarm_ctrl;
			polarity_sync_ctrl <= dac_cfg_pkg::rst_polarity_sync;
			channel_route_sync_source <= dac_cfg_pkg::rst_route_sync;
		end else begin
			expected_word_zero <= next_expected_word_zero;
			expected_word_one <= next_expected_word_one;
			expected_word_two <= next_expected_word_two;
			expected_word_three <= next_expected_word_three;
			expected_word_four <= next_expected_word_four;
			expected_word_five <= next_expected_word_five;
			expected_word_six <= next_expected_word_six;
			expected_word_seven <= next_expected_word_seven;
			alarm_mask_enable_ctrl <= next_alarm_mask_enable_ctrl;
			polarity_sync_ctrl <= next_polarity_sync_ctrl;
			channel_route_sync_source <= next_channel_route_sync_source;
		end
	end

	// ****************************************
	// pattern checker
	// ****************************************
	assign expected_all = {expected_word_seven, expected_word_six, expected_word_five,
		expected_word_four, expected_word_three, expected_word_two, expected_word_one,
		expected_word_zero};

	pattern_checker #(
		.words(dac_cfg_pkg::word_count)
	) u_checker (
		.clk(clk),
		.rst_b(rst_b),
		.enable(check_enable),
		.byte_valid(byte_valid),
		.byte_in(byte_in),
		.expected(expected_all),
		.clear_results(clear_results),
		.clear_alarm(clear_alarm),
		.results(check_results),
		.alarm(check_alarm)
	);

	// ****************************************
	// alarms
	// ****************************************
	logic clk_alarm_event;
	logic next_clk_alarm_status;
	logic next_tx_off_status;
	logic next_alarm_output_pin;

	always_comb begin
		clk_alarm_event = clk_monitor_fault &
			alarm_mask_enable_ctrl[dac_cfg_pkg::bit_clk_alarm_ena]; // [R5]
		next_clk_alarm_status = clk_alarm_status | clk_alarm_event; // [R3]
		next_tx_off_status = tx_off_status | tx_enable_fault; // [R4]
		next_alarm_output_pin =
			(next_clk_alarm_status & ~alarm_mask_enable_ctrl[dac_cfg_pkg::bit_clk_alarm_mask]) | // [R3]
			(next_tx_off_status & ~alarm_mask_enable_ctrl[dac_cfg_pkg::bit_tx_off_mask]); // [R4]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_alarm_status <= 1'b0;
			tx_off_status <= 1'b0;
			alarm_output_pin <= 1'b0;
		end else begin
			clk_alarm_status <= next_clk_alarm_status;
			tx_off_status <= next_tx_off_status;
			alarm_output_pin <= next_alarm_output_pin;
		end
	end

	// ****************************************
	// data path
	// ****************************************
	dac_cfg_pkg::sample_pair_t routed;
	dac_cfg_pkg::sample_pair_t shaped;
	dac_cfg_pkg::sample_pair_t next_sample_out;

	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_rev
			always_comb begin
				shaped.a[g] = channel_route_sync_source[dac_cfg_pkg::bit_reverse] ?
					sample_in.a[15-g] : sample_in.a[g]; // [R13]
				shaped.b[g] = channel_route_sync_source[dac_cfg_pkg::bit_reverse] ?
					sample_in.b[15-g] : sample_in.b[g]; // [R13]
			end
		end
	endgenerate

	always_comb begin
		routed = shaped;
		if (channel_route_sync_source[dac_cfg_pkg::bit_copy_a_to_b]) begin
			routed.b = shaped.a; // [R11]
		end
		if (channel_route_sync_source[dac_cfg_pkg::bit_copy_b_to_a]) begin
			routed.a = shaped.b; // [R12]
		end
		if (polarity_sync_ctrl[dac_cfg_pkg::bit_a_complement]) begin
			routed.a = ~routed.a; // [R7]
		end
		if (polarity_sync_ctrl[dac_cfg_pkg::bit_b_complement]) begin
			routed.b = ~routed.b; // [R8]
		end
		next_sample_out = routed;
		if (alarm_mask_enable_ctrl[dac_cfg_pkg::bit_auto_off_ena] & next_clk_alarm_status) begin
			next_sample_out.a = dac_cfg_pkg::midscale; // [R6]
			next_sample_out.b = dac_cfg_pkg::midscale; // [R6]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_out <= '{a: dac_cfg_pkg::midscale, b: dac_cfg_pkg::midscale};
		end else begin
			sample_out <= next_sample_out;
		end
	end

	// ****************************************
	// sync source
	// ****************************************
	logic sync_src;
	logic sync_src_d;
	logic next_multi_sync_pulse;
	logic [div_width-1:0] next_divider_phase;

	always_comb begin
		sync_src = channel_route_sync_source[dac_cfg_pkg::bit_sync_sel] ?
			frame_marker : external_sync_strobe; // [R10]
		next_multi_sync_pulse = sync_src & ~sync_src_d;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_src_d <= 1'b0;
			multi_sync_pulse <= 1'b0;
		end else begin
			sync_src_d <= sync_src;
			multi_sync_pulse <= next_multi_sync_pulse;
		end
	end

	// ****************************************
	// clock divider
	// ****************************************
	always_comb begin
		next_divider_phase = divider_phase + 1'b1;
		if (polarity_sync_ctrl[dac_cfg_pkg::bit_div_sync_ena] & next_multi_sync_pulse) begin
			next_divider_phase = '0; // [R9]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			divider_phase <= '0;
		end else begin
			divider_phase <= next_divider_phase;
		end
	end
endmodule : dac_datapath_cfg

//--- hw/dac_cfg_pkg.sv
package dac_cfg_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [6:0] addr_word3 = 7'h0C;
	localparam logic [6:0] addr_word4 = 7'h0D;
	localparam logic [6:0] addr_word5 = 7'h0E;
	localparam logic [6:0] addr_word6 = 7'h0F;
	localparam logic [6:0] addr_word7 = 7'h10;
	localparam logic [6:0] addr_alarm_ctrl = 7'h11;
	localparam logic [6:0] addr_polarity_sync = 7'h12;
	localparam logic [6:0] addr_route_sync = 7'h13;
	localparam logic [6:0] addr_check_status = 7'h07;
	localparam logic [6:0] addr_check_results = 7'h08;
	localparam logic [6:0] addr_word0 = 7'h09;
	localparam logic [6:0] addr_word1 = 7'h0A;
	localparam logic [6:0] addr_word2 = 7'h0B;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] rst_word0 = 8'h7A;
	localparam logic [7:0] rst_word1 = 8'hB6;
	localparam logic [7:0] rst_word2 = 8'hEA;
	localparam logic [7:0] rst_word3 = 8'h45;
	localparam logic [7:0] rst_word4 = 8'h1A;
	localparam logic [7:0] rst_word5 = 8'h16;
	localparam logic [7:0] rst_word6 = 8'hAA;
	localparam logic [7:0] rst_word7 = 8'hC6;
	localparam logic [7:0] rst_alarm_ctrl = 8'h24;
	localparam logic [7:0] rst_polarity_sync = 8'h02;
	localparam logic [7:0] rst_route_sync = 8'h00;
	// ****************************************
	// field positions
	// ****************************************
	localparam int bit_clk_alarm_mask = 4;
	localparam int bit_tx_off_mask = 3;
	localparam int bit_clk_alarm_ena = 1;
	localparam int bit_auto_off_ena = 0;
	localparam int bit_a_complement = 3;
	localparam int bit_b_complement = 2;
	localparam int bit_div_sync_ena = 1;
	localparam int bit_copy_a_to_b = 7;
	localparam int bit_copy_b_to_a = 6;
	localparam int bit_sync_sel = 1;
	localparam int bit_reverse = 0;
	localparam int bit_check_alarm = 3;
	localparam int word_count = 8;
	localparam logic [15:0] midscale = 16'h8000;
	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic [15:0] a;
		logic [15:0] b;
	} sample_pair_t;
endpackage : dac_cfg_pkg

//--- hw/pattern_checker.sv
`timescale 1ns/100ps
module pattern_checker #(
	parameter int words = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	input wire logic [words*8-1:0] expected,
	input wire logic clear_results,
	input wire logic clear_alarm,
	output logic [7:0] results,
	output logic alarm
);
	logic [$clog2(words)-1:0] index;
	logic [$clog2(words)-1:0] next_index;
	logic [7:0] next_results;
	logic next_alarm;
	logic [7:0] diff;

	// ****************************************
	// compare each byte to its word
	// ****************************************
	always_comb begin
		diff = 8'h00;
		next_index = index;
		next_results = clear_results ? 8'h00 : results;
		next_alarm = clear_alarm ? 1'b0 : alarm;
		if (!enable) begin
			next_index = '0;
		end else if (byte_valid) begin
			diff = byte_in ^ expected[index*8 +: 8]; // [R16]
			next_index = index + 1'b1; // [R16]
			next_results = next_results | diff; // [R15] set wins
			if (diff != 8'h00) begin
				next_alarm = 1'b1; // [R14] set wins
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			index <= '0;
			results <= 8'h00;
			alarm <= 1'b0;
		end else begin
			index <= next_index;
			results <= next_results;
			alarm <= next_alarm;
		end
	end
endmodule : pattern_checker

//--- verif/dac_cfg_properties.sv
`timescale 1ns/100ps
// ****************************************
// port checker
// ****************************************
module dac_cfg_properties #(
	parameter int div_width = 2
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire dac_cfg_pkg::reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic check_enable,
	input wire logic byte_valid,
	input wire logic [7:0] byte_in,
	input wire dac_cfg_pkg::sample_pair_t sample_in,
	input wire logic clk_monitor_fault,
	input wire logic tx_enable_fault,
	input wire logic external_sync_strobe,
	input wire logic frame_marker,
	input wire dac_cfg_pkg::sample_pair_t sample_out,
	input wire logic alarm_output_pin,
	input wire logic clk_alarm_status,
	input wire logic tx_off_status,
	input wire logic multi_sync_pulse,
	input wire logic [div_width-1:0] divider_phase
);
	logic [7:0] actl;
	logic [7:0] pol;
	logic [7:0] route;
	logic [7:0] next_actl;
	logic [7:0] next_pol;
	logic [7:0] next_route;
	logic src;
	// shadow copies of control registers
	always_comb begin
		next_actl = actl;
		next_pol = pol;
		next_route = route;
		if (reg_req.wr && reg_req.addr == dac_cfg_pkg::addr_alarm_ctrl) next_actl = reg_req.wdata;
		if (reg_req.wr && reg_req.addr == dac_cfg_pkg::addr_polarity_sync) next_pol = reg_req.wdata;
		if (reg_req.wr && reg_req.addr == dac_cfg_pkg::addr_route_sync) next_route = reg_req.wdata;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			actl <= dac_cfg_pkg::rst_alarm_ctrl;
			pol <= dac_cfg_pkg::rst_polarity_sync;
			route <= dac_cfg_pkg::rst_route_sync;
		end else begin
			actl <= next_actl;
			pol <= next_pol;
			route <= next_route;
		end
	end
	assign src = route[1] ? frame_marker : external_sync_strobe;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_rdata_idle_zero: assert property (
		!$past(reg_req.rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
	a_clk_status_set: assert property (
		clk_monitor_fault && actl[1] |=> clk_alarm_status) else $error("clock status missed");
	a_clk_status_gate: assert property (
		$rose(clk_alarm_status) |-> $past(clk_monitor_fault) && $past(actl[1]))
		else $error("clock status without enable");
	a_tx_status_set: assert property (
		tx_enable_fault |=> tx_off_status) else $error("tx status missed");
	a_tx_pin_unmasked: assert property (
		tx_enable_fault && !actl[3] |=> alarm_output_pin) else $error("tx alarm not on pin");
	a_clk_pin_masked: assert property (
		clk_monitor_fault && actl[1] && actl[4] && !tx_off_status && !tx_enable_fault
		|=> !alarm_output_pin) else $error("masked clock alarm on pin");
	a_auto_midscale: assert property (
		clk_monitor_fault && actl[1] && actl[0]
		|=> sample_out == {dac_cfg_pkg::midscale, dac_cfg_pkg::midscale})
		else $error("outputs not at midscale");
	a_both_complement: assert property (
		route == 8'h00 && pol[3:2] == 2'b11 && !actl[0] |=> sample_out == ~$past(sample_in))
		else $error("complement wrong");
	a_sync_source_pulse: assert property (
		$rose(src) && $stable(route) |=> multi_sync_pulse) else $error("sync pulse missed");
	a_divider_align: assert property (
		$rose(src) && $stable(route) && pol[1] |=> divider_phase == '0)
		else $error("divider not aligned");
endmodule : dac_cfg_properties

//--- verif/pattern_source.sv
`timescale 1ns/100ps
// ****************************************
// byte source for the pattern check
// ****************************************
module pattern_source (
	input wire logic clk,
	input wire logic run,
	input wire logic [63:0] words,
	input wire logic [2:0] bad_idx,
	input wire logic [7:0] bad_mask,
	output logic check_enable,
	output logic byte_valid,
	output logic [7:0] byte_in
);
	logic [2:0] idx = 3'h0;
	assign check_enable = run;
	initial begin
		byte_valid = 1'b0;
		byte_in = 8'h00;
	end
	always @(posedge clk) begin
		if (run) begin
			// words zero to seven in order, one marked word spoiled
			byte_valid <= 1'b1;
			byte_in <= words[idx*8 +: 8] ^ ((idx == bad_idx) ? bad_mask : 8'h00);
			idx <= idx + 3'h1;
		end else begin
			byte_valid <= 1'b0;
			byte_in <= ~byte_in;
			idx <= 3'h0;
		end
	end
endmodule : pattern_source

//--- verif/dac_datapath_test_alarm_config_bench.sv
`timescale 1ns/100ps
// ****************************************
// bench
// ****************************************
module dac_datapath_test_alarm_config_bench;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	dac_cfg_pkg::reg_req_t reg_req = '0;
	dac_cfg_pkg::sample_pair_t sample_in = '0;
	dac_cfg_pkg::sample_pair_t sample_out;
	logic [7:0] reg_rdata;
	logic [7:0] byte_in;
	logic [7:0] bad_mask = 8'h00;
	logic [2:0] bad_idx = 3'h0;
	logic [1:0] divider_phase;
	logic [1:0] flt = 2'b00;
	logic [1:0] syn = 2'b00;
	logic [63:0] words = '0;
	logic check_enable, byte_valid, run = 1'b0, pin, clk_st, tx_st, pulse;
	int miscompares = 0;
	int compares = 0;
	int model [int];
	int rst_tab [11] = '{8'h7A, 8'hB6, 8'hEA, 8'h45, 8'h1A, 8'h16, 8'hAA, 8'hC6, 8'h24, 8'h02, 8'h00};
	int unsigned v;
	always #2 clk = ~clk;
	dac_datapath_cfg #(.div_width(2)) i_dut (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .check_enable(check_enable), .byte_valid(byte_valid),
		.byte_in(byte_in), .sample_in(sample_in), .clk_monitor_fault(flt[1]),
		.tx_enable_fault(flt[0]), .external_sync_strobe(syn[0]), .frame_marker(syn[1]),
		.sample_out(sample_out), .alarm_output_pin(pin), .clk_alarm_status(clk_st),
		.tx_off_status(tx_st), .multi_sync_pulse(pulse), .divider_phase(divider_phase));
	pattern_source i_src (.clk(clk), .run(run), .words(words), .bad_idx(bad_idx),
		.bad_mask(bad_mask), .check_enable(check_enable), .byte_valid(byte_valid),
		.byte_in(byte_in));
	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_req = '{1'b1, 1'b0, a, d};
		@(negedge clk);
		reg_req = '0;
		if (model.exists(a)) model[a] = d;
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		reg_req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk);
		d = reg_rdata;
		reg_req = '0;
		@(negedge clk);
	endtask : rd
	task automatic rd_chk(input logic [6:0] a);
		logic [7:0] d;
		rd(a, d);
		check(d, model.exists(a) ? model[a] : 0);
	endtask : rd_chk
	task automatic do_reset();
		rst_b = 1'b0;
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 11; i++) model[9+i] = rst_tab[i];
	endtask : do_reset
	task automatic fault(input logic [1:0] f);
		flt = f;
		@(negedge clk);
		flt = 2'b00;
		@(negedge clk);
	endtask : fault
	task automatic run_src(input logic [7:0] m);
		bad_mask = m;
		run = 1'b1;
		repeat (16) @(negedge clk);
		run = 1'b0;
		repeat (3) @(negedge clk);
	endtask : run_src
	function automatic logic [31:0] path(input logic [31:0] s);
		logic [15:0] a, b, t;
		a = s[31:16];
		b = s[15:0];
		if (model['h13] & 1) begin
			a = {<<{a}};
			b = {<<{b}};
		end
		t = a;
		if (model['h13] & 'h40) a = b;
		if (model['h13] & 'h80) b = t;
		if (model['h12] & 8) a = ~a;
		if (model['h12] & 4) b = ~b;
		return {a, b};
	endfunction : path
	task automatic final_report();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report
	// ****************************************
	// tests
	// ****************************************
	initial begin
		#20000;
		miscompares++;
		final_report();
	end
	initial begin
		logic [7:0] d;
		logic [1:0] p;
		v = $urandom(51286);
		do_reset();
		for (int i = 'h07; i <= 'h14; i++) if (i > 8) rd_chk(i[6:0]);
		for (int i = 'h0C; i <= 'h10; i++) wr(i[6:0], 8'($urandom));
		for (int i = 'h0C; i <= 'h10; i++) rd_chk(i[6:0]);
		$display("test registers done");
		for (int i = 0; i < 8; i++) words[i*8 +: 8] = 8'(model[9+i]);
		run_src(8'h00);
		rd(7'h08, d);
		check(d, 0);
		bad_idx = 3'($urandom_range(6));
		run_src(8'($urandom_range(255, 1)));
		rd(7'h08, d);
		check(d, bad_mask);
		rd(7'h07, d);
		check(d & 8'h08, 8'h08);
		wr(7'h07, 8'h08);
		wr(7'h08, 8'hFF);
		rd(7'h07, d);
		check(d, 0);
		rd(7'h08, d);
		check(d, 0);
		$display("test pattern done");
		for (int k = 0; k < 16; k++) begin
			wr(7'h13, {k[1:0], 5'h00, k[2]});
			wr(7'h12, {4'h0, k[3] ? 2'b11 : 2'($urandom), 2'b10});
			sample_in = $urandom;
			@(negedge clk);
			check(sample_out, path(sample_in));
		end
		$display("test datapath done");
		wr(7'h11, 8'h12);
		fault(2'b10);
		check({clk_st, tx_st, pin}, 3'b100);
		wr(7'h11, 8'h1A);
		fault(2'b11);
		check({clk_st, tx_st, pin}, 3'b110);
		wr(7'h11, 8'h02);
		@(negedge clk);
		check(pin, 1);
		do_reset();
		wr(7'h11, 8'h01);
		fault(2'b10);
		check({clk_st, pin, sample_out}, {2'b00, path(sample_in)});
		wr(7'h11, 8'h03);
		fault(2'b10);
		check({clk_st, pin, sample_out}, 34'h380008000);
		fault(2'b01);
		check({tx_st, pin}, 2'b11);
		$display("test alarms done");
		do_reset();
		for (int s = 0; s < 4; s++) begin
			wr(7'h13, {6'h00, s[0], 1'b0});
			wr(7'h12, {6'h00, !s[1], 1'b0});
			repeat ($urandom_range(3)) @(negedge clk);
			p = divider_phase;
			syn = s[0] ? 2'b10 : 2'b01;
			@(negedge clk);
			check({pulse, divider_phase}, {1'b1, s[1] ? 2'(p + 1) : 2'b00});
			syn = 2'b00;
			@(negedge clk);
			syn = s[0] ? 2'b01 : 2'b10;
			@(negedge clk);
			check(pulse, 0);
			syn = 2'b00;
			@(negedge clk);
		end
		$display("test sync done");
		final_report();
	end
endmodule : dac_datapath_test_alarm_config_bench
bind dac_datapath_cfg dac_cfg_properties #(.div_width(div_width)) i_props (.clk(clk),
	.rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata), .check_enable(check_enable),
	.byte_valid(byte_valid), .byte_in(byte_in), .sample_in(sample_in),
	.clk_monitor_fault(clk_monitor_fault), .tx_enable_fault(tx_enable_fault),
	.external_sync_strobe(external_sync_strobe), .frame_marker(frame_marker),
	.sample_out(sample_out), .alarm_output_pin(alarm_output_pin),
	.clk_alarm_status(clk_alarm_status), .tx_off_status(tx_off_status),
	.multi_sync_pulse(multi_sync_pulse), .divider_phase(divider_phase));
